// file: design/fault_alarm_pkg.sv
`default_nettype none
package fault_alarm_pkg;
    // register map, word addresses of the management space
    localparam logic [15:0] ADDR_FATAL_FAULT = 16'hb01e;
    localparam logic [15:0] ADDR_ALARM_WORD1 = 16'hb01f;
    localparam logic [15:0] ADDR_ALARM_WORD2 = 16'hb020;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hb0f0;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hb0f1;
    localparam logic [15:0] ADDR_MODULE_STATE = 16'hb0f2;
    localparam logic [15:0] ADDR_SUPPLY_ENABLE = 16'hb0f3;
    // fault word fields
    localparam int FLT_CHECKSUM = 1;
    localparam int FLT_SUPPLY = 5;
    localparam int FLT_INIT = 6;
    localparam logic [15:0] FAULT_USED_MASK = 16'h0062;
    // alarm word 1 field bases (high alarm, high warn, low warn, low alarm)
    localparam int AW1_TEMP_LSB = 8;
    localparam int AW1_SUPPLY_LSB = 4;
    localparam int AW1_AMP_LSB = 0;
    // alarm word 2 field base
    localparam int AW2_AUX1_LSB = 4;
    localparam logic [15:0] AW1_USED_MASK = 16'h0fff;
    localparam logic [15:0] AW2_USED_MASK = 16'h00f0;
    // reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic SUPPLY_ENABLE_RESET = 1'b1;
    // interrupt status bits, then the supply fault input width
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_ALARM1 = 1;
    localparam int IRQ_ALARM2 = 2;
    localparam int SUPPLY_FAULT_W = 8;
    // module state encoding, only the fault state matters here
    typedef enum logic [1:0]
    {
        MOD_NORMAL = 2'b00,
        MOD_FAULT = 2'b01
    } module_state_t;
endpackage
`default_nettype wire

// file: design/module_fault_alarm_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - fault bit 6 set when programmable logic or config memory init fails.
// - fault bit 5 is OR of supply faults, plus enabled supply alarm bits.
// - word1 bits 11..8 are temperature high alarm, high warn, low warn, low alarm.
// - word1 bits 7..4 are primary supply high alarm, high warn, low warn, low alarm.
// - word1 bits 3..0 are amplifier bias high alarm, high warn, low warn, low alarm.
// - word2 bits 7..4 are auxiliary channel 1 high/low alarm and warning flags.
// - any fault bit set forces the module state into fault state.
module module_fault_alarm_status_regs
    import fault_alarm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    // monitor inputs, asynchronous levels
    input wire logic initFail,
    input wire logic checksumFail,
    input wire logic [SUPPLY_FAULT_W-1:0] supplyFault,
    input wire logic [3:0] tempFlags,
    input wire logic [3:0] supplyFlags,
    input wire logic [3:0] ampFlags,
    input wire logic [3:0] aux1Flags,
    // status outputs
    output logic [1:0] moduleState,
    output logic irq
);
    localparam int SYNC_W = 18 + SUPPLY_FAULT_W;

    typedef struct packed
    {
        logic [15:0] fault;
        logic [15:0] word1;
        logic [15:0] word2;
        logic supplyAlarmEn;
        module_state_t state;
        logic [15:0] rdData;
    } regs_state_t;

    regs_state_t st_q;
    regs_state_t st_d;
    logic [SYNC_W-1:0] asyncFlags;
    logic [SYNC_W-1:0] syncFlags;
    logic [2:0] irqEvents;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic irqClr;
    logic irqMaskWr;
    logic sInit;
    logic sChecksum;
    logic [SUPPLY_FAULT_W-1:0] sSupply;
    logic [3:0] sTemp;
    logic [3:0] sSupplyAl;
    logic [3:0] sAmp;
    logic [3:0] sAux1;

    //////////////////////////////////////////////////////////////////////////
    // pack the monitor levels in the order they are unpacked after the stages
    assign asyncFlags = {
        initFail,
        checksumFail,
        supplyFault,
        tempFlags,
        supplyFlags,
        ampFlags,
        aux1Flags
    };

    // monitor flags come from other clock domains, synchronise them all
    sync_word #(.WIDTH(SYNC_W)) u_sync (
        .sysClk(sys_clk),
        .rstN(rst_n),
        .asyncIn(asyncFlags),
        .syncOut(syncFlags)
    );

    assign {sInit, sChecksum, sSupply, sTemp, sSupplyAl, sAmp, sAux1} = syncFlags;

    //////////////////////////////////////////////////////////////////////////
    // read decode shared by the read mux
    function automatic logic [15:0] read_word(input logic [15:0] addr,
                                              input regs_state_t s,
                                              input logic [2:0] ist,
                                              input logic [2:0] imk);
        logic [15:0] r;
        r = 16'h0000;
        if (addr == ADDR_FATAL_FAULT)
        begin
            r = s.fault & FAULT_USED_MASK;
        end
        else if (addr == ADDR_ALARM_WORD1)
        begin
            r = s.word1 & AW1_USED_MASK;
        end
        else if (addr == ADDR_ALARM_WORD2)
        begin
            r = s.word2 & AW2_USED_MASK;
        end
        else if (addr == ADDR_IRQ_STATUS)
        begin
            r = {13'h0000, ist};
        end
        else if (addr == ADDR_IRQ_MASK)
        begin
            r = {13'h0000, imk};
        end
        else if (addr == ADDR_MODULE_STATE)
        begin
            r = {14'h0000, s.state};
        end
        else if (addr == ADDR_SUPPLY_ENABLE)
        begin
            r = {15'h0000, s.supplyAlarmEn};
        end
        return r;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // write decode, shared by the control and interrupt registers
    function automatic logic write_hit(input logic stb,
                                       input logic [15:0] addr,
                                       input logic [15:0] target);
        return stb && addr == target;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // status words track the monitors; only interrupt and control are writable
    // words are live, not latched: a blip between two reads is kept only by
    // the sticky interrupt status, which is why every rising bit is an event
    always_comb
    begin
        st_d = st_q;
        st_d.word1 = WORD_RESET;
        st_d.word1[AW1_TEMP_LSB +: 4] = sTemp;
        st_d.word1[AW1_SUPPLY_LSB +: 4] = sSupplyAl;
        st_d.word1[AW1_AMP_LSB +: 4] = sAmp;
        st_d.word2 = WORD_RESET;
        st_d.word2[AW2_AUX1_LSB +: 4] = sAux1;
        st_d.fault = WORD_RESET;
        st_d.fault[FLT_INIT] = sInit;
        st_d.fault[FLT_CHECKSUM] = sChecksum;
        st_d.fault[FLT_SUPPLY] = (|sSupply) | (st_q.supplyAlarmEn & (|sSupplyAl));
        // fault state follows the registered fault word
        st_d.state = (|st_q.fault) ? MOD_FAULT : MOD_NORMAL;
        if (write_hit(regWrStb, regAddr, ADDR_SUPPLY_ENABLE))
        begin
            st_d.supplyAlarmEn = regWrData[0];
        end
        // writes to status word addresses fall through untouched
        st_d.rdData = regRdStb ? read_word(regAddr, st_q, irqStatus, irqMask) : 16'h0000;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q.fault <= WORD_RESET;
            st_q.word1 <= WORD_RESET;
            st_q.word2 <= WORD_RESET;
            st_q.supplyAlarmEn <= SUPPLY_ENABLE_RESET;
            st_q.state <= MOD_NORMAL;
            st_q.rdData <= WORD_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // rising edges of any word raising a bit become interrupt events
    assign irqEvents[IRQ_FAULT] = |(st_d.fault & ~st_q.fault);
    assign irqEvents[IRQ_ALARM1] = |(st_d.word1 & ~st_q.word1);
    assign irqEvents[IRQ_ALARM2] = |(st_d.word2 & ~st_q.word2);
    assign irqClr = write_hit(regWrStb, regAddr, ADDR_IRQ_STATUS);
    assign irqMaskWr = write_hit(regWrStb, regAddr, ADDR_IRQ_MASK);

    sticky_irq #(.WIDTH(3)) u_irq (
        .sysClk(sys_clk),
        .rstN(rst_n),
        .eventPulse(irqEvents),
        .clearStrobe(irqClr),
        .clearBits(regWrData[2:0]),
        .maskStrobe(irqMaskWr),
        .maskBits(regWrData[2:0]),
        .statusBits(irqStatus),
        .maskValue(irqMask),
        .irqOut(irq)
    );

    assign regRdData = st_q.rdData;
    assign moduleState = st_q.state;

    //////////////////////////////////////////////////////////////////////////
    // checks on the fault word
    // a failed logic load must show in the fault word one edge later
    a_init_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sInit) |=> st_q.fault[FLT_INIT])
        else $error("init fault bit not set");
    // the bit is live, so it drops again with its monitor
    a_init_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(sInit) |=> !st_q.fault[FLT_INIT])
        else $error("init fault bit stuck after its monitor cleared");
    // supply bit is the OR of every supply fault and the enabled alarms
    a_supply_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q.fault[FLT_SUPPLY] == $past((|sSupply) | (st_q.supplyAlarmEn & (|sSupplyAl))))
        else $error("supply fault bit is not the OR of its sources");
    // with the alarm path off, only a real supply fault may raise the bit
    a_supply_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !st_q.supplyAlarmEn && !(|sSupply) |=> !st_q.fault[FLT_SUPPLY])
        else $error("supply fault raised by a gated alarm");
    // the enable takes the written bit on the next edge
    a_supply_en_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        write_hit(regWrStb, regAddr, ADDR_SUPPLY_ENABLE) |=>
        st_q.supplyAlarmEn == $past(regWrData[0]))
        else $error("supply alarm enable not written");
    // a failed checksum is fatal as well
    a_checksum_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sChecksum) |=> st_q.fault[FLT_CHECKSUM])
        else $error("checksum fault bit not set");
    // reserved fault bits never reach the bus
    a_fault_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regRdStb && regAddr == ADDR_FATAL_FAULT |=>
        (regRdData & ~FAULT_USED_MASK) == 16'h0000)
        else $error("reserved fault bits read non-zero");
    // host writes must leave the fault word alone while its sources hold
    a_ro_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrStb && regAddr == ADDR_FATAL_FAULT && $stable(syncFlags) &&
        $stable(st_q.supplyAlarmEn) |=> $stable(st_q.fault))
        else $error("write changed fault word");

    //////////////////////////////////////////////////////////////////////////
    // checks on the module state
    // any fault bit forces the fault state one edge later
    a_fault_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|st_q.fault) |=> moduleState == MOD_FAULT)
        else $error("fault word set but state not fault");
    // a clean fault word lets the state fall back to normal
    a_state_normal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(|st_q.fault) |=> moduleState == MOD_NORMAL)
        else $error("state held in fault with a clean fault word");

    //////////////////////////////////////////////////////////////////////////
    // checks on the alarm words
    // each group lands in its own nibble one edge after synchronisation
    a_temp_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 st_q.word1[11:8] == $past(sTemp))
        else $error("temperature flags misplaced");
    a_supply_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 st_q.word1[7:4] == $past(sSupplyAl))
        else $error("supply alarm flags misplaced");
    a_amp_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 st_q.word1[3:0] == $past(sAmp))
        else $error("amplifier flags misplaced");
    a_aux_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 st_q.word2[7:4] == $past(sAux1))
        else $error("aux channel flags misplaced");
    // a word1 read returns the word of the strobe cycle, top nibble zero
    a_read_word1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regRdStb && regAddr == ADDR_ALARM_WORD1 |=>
        regRdData == {4'h0, $past(st_q.word1[11:0])})
        else $error("word1 read does not match the word");
    // reserved bits of word2 read zero
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regRdStb && regAddr == ADDR_ALARM_WORD2 |=> regRdData[15:8] == 8'h00 &&
        regRdData[3:0] == 4'h0)
        else $error("reserved bits read non-zero");
    // the alarm words ignore host writes as long as the monitors hold
    a_ro_word1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrStb && regAddr == ADDR_ALARM_WORD1 && $stable(syncFlags) |=> $stable(st_q.word1))
        else $error("write changed alarm word 1");
    a_ro_word2: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrStb && regAddr == ADDR_ALARM_WORD2 && $stable(syncFlags) |=> $stable(st_q.word2))
        else $error("write changed alarm word 2");

    //////////////////////////////////////////////////////////////////////////
    // checks on the register port and interrupt events
    // read data stand one cycle only, zero at every other time
    a_rd_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !regRdStb |=> regRdData == 16'h0000)
        else $error("read data outside the answer cycle");
    // a rising fault bit must reach the sticky status, even against a clear
    a_fault_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|(st_d.fault & ~st_q.fault)) |=> irqStatus[IRQ_FAULT])
        else $error("fault event lost");
    // a rising word1 bit must reach its sticky status bit
    a_alarm_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|(st_d.word1 & ~st_q.word1)) |=> irqStatus[IRQ_ALARM1])
        else $error("alarm word 1 event lost");
    // the mask takes the written bits on the next edge
    a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irqMaskWr |=> irqMask == $past(regWrData[2:0]))
        else $error("interrupt mask not written");

    //////////////////////////////////////////////////////////////////////////
    // main scenarios
    c_fault_seen: cover property (@(posedge sys_clk) disable iff (!rst_n)
        moduleState == MOD_FAULT);
    c_irq_raised: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
    c_read_word1: cover property (@(posedge sys_clk) disable iff (!rst_n)
        regRdStb && regAddr == ADDR_ALARM_WORD1 ##1 regRdData != 16'h0000);
    c_supply_gated: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !st_q.supplyAlarmEn && (|sSupplyAl));
    c_irq_cleared: cover property (@(posedge sys_clk) disable iff (!rst_n)
        irqClr && (|irqStatus));
endmodule
`default_nettype wire

// file: design/sticky_irq.sv
`timescale 1ns/1ps
`default_nettype none
// sticky event bits, write-one-to-clear, masked onto one level output
module sticky_irq
    import fault_alarm_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    // clock and reset
    input wire logic sysClk,
    input wire logic rstN,
    // events and software access
    input wire logic [WIDTH-1:0] eventPulse,
    input wire logic clearStrobe,
    input wire logic [WIDTH-1:0] clearBits,
    input wire logic maskStrobe,
    input wire logic [WIDTH-1:0] maskBits,
    // state
    output logic [WIDTH-1:0] statusBits,
    output logic [WIDTH-1:0] maskValue,
    output logic irqOut
);
    typedef struct packed
    {
        logic [WIDTH-1:0] status;
        logic [WIDTH-1:0] mask;
    } irq_state_t;

    irq_state_t state_q;
    irq_state_t state_d;

    // set wins over a clear in the same cycle so no event is lost
    always_comb
    begin
        state_d = state_q;
        if (clearStrobe)
        begin
            state_d.status = state_q.status & ~clearBits;
        end
        state_d.status = state_d.status | eventPulse;
        if (maskStrobe)
        begin
            state_d.mask = maskBits;
        end
    end

    always_ff @(posedge sysClk)
    begin
        if (!rstN)
        begin
            state_q.status <= '0;
            state_q.mask <= IRQ_MASK_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign statusBits = state_q.status;
    assign maskValue = state_q.mask;
    assign irqOut = |(state_q.status & state_q.mask);

    // an unmasked event must raise the output one edge later
    a_irq_level: assert property (@(posedge sysClk) disable iff (!rstN)
        (|(eventPulse & maskValue)) && !maskStrobe |=> irqOut)
        else $error("unmasked event did not raise irq");
    // every event bit lands, even against a clear of the same bit
    a_set_wins: assert property (@(posedge sysClk) disable iff (!rstN)
        (|eventPulse) |=> (statusBits & $past(eventPulse)) == $past(eventPulse))
        else $error("event lost against clear");
    // a clear with no event empties the bits written as one
    a_clear_w1c: assert property (@(posedge sysClk) disable iff (!rstN)
        clearStrobe && !(|eventPulse) |=> (statusBits & $past(clearBits)) == '0)
        else $error("cleared status bit still set");
endmodule
`default_nettype wire

// file: design/sync_word.sv
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for a bus of independent level flags
module sync_word
    import fault_alarm_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input wire logic sysClk,
    input wire logic rstN,
    // flags
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    // first stage is read only by the second
    always_comb
    begin
        state_d.meta = asyncIn;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sysClk)
    begin
        if (!rstN)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stable;
endmodule
`default_nettype wire

// file: verif/host_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the management port: one request at a time, one-cycle strobes
module host_mgmt_model
(
    // clock
    input wire logic sys_clk,
    // register port
    output logic [15:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWrStb,
    output logic regRdStb,
    input wire logic [15:0] regRdData
);
    // idle port at time zero
    initial
    begin
        regAddr = 16'h0000;
        regWrData = 16'h0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end

    // write strobe stands beside address and data for one cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        @(negedge sys_clk);
        d = regRdData;
    endtask
endmodule
`default_nettype wire

// file: verif/test_module_fault_alarm_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_module_fault_alarm_status_regs
    import fault_alarm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] regAddr, regWrData, regRdData, rdv;
    logic regWrStb, regRdStb, irq, supEn = 1'b1;
    logic initFail = 1'b0, checksumFail = 1'b0;
    logic [7:0] supplyFault = 8'h00;
    logic [3:0] tempFlags = 4'h0, supplyFlags = 4'h0, ampFlags = 4'h0, aux1Flags = 4'h0;
    logic [1:0] moduleState;
    logic [15:0] roA [4];
    int nFail = 0;
    int cmpCount = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    module_fault_alarm_status_regs u_module_fault_alarm_status_regs (.sys_clk(sys_clk),
        .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .initFail(initFail),
        .checksumFail(checksumFail), .supplyFault(supplyFault), .tempFlags(tempFlags),
        .supplyFlags(supplyFlags), .ampFlags(ampFlags), .aux1Flags(aux1Flags),
        .moduleState(moduleState), .irq(irq));

    host_mgmt_model u_host_mgmt_model (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData));

    //////////////////////////////////////////////////////////////////////////////
    // expected words, built from the monitor levels we drive
    function automatic logic [15:0] expReg(input logic [15:0] a);
        logic [15:0] f;
        f = 16'h0000;
        f[FLT_INIT] = initFail;
        f[FLT_SUPPLY] = (|supplyFault) | (supEn & (|supplyFlags));
        f[FLT_CHECKSUM] = checksumFail;
        case (a)
            ADDR_FATAL_FAULT: expReg = f;
            ADDR_ALARM_WORD1: expReg = {4'h0, tempFlags, supplyFlags, ampFlags};
            ADDR_ALARM_WORD2: expReg = {8'h00, aux1Flags, 4'h0};
            default: expReg = (f != 16'h0000) ? {14'h0, MOD_FAULT} : {14'h0, MOD_NORMAL};
        endcase
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            nFail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
        u_host_mgmt_model.rd(a, rdv);
        chk(rdv, exp);
    endtask

    // monitors need two sync stages plus the word and state registers
    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic waitIrq(input logic exp);
        int n = 0;
        // look only mid-cycle, never in the edge that launches irq
        @(negedge sys_clk);
        while (irq !== exp && n < 10)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({15'h0, irq}, {15'h0, exp});
        if (n == 10)
            report_and_stop();
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // hang guard, counted as a mismatch
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        roA = '{ADDR_FATAL_FAULT, ADDR_ALARM_WORD1, ADDR_ALARM_WORD2, ADDR_MODULE_STATE};
        void'($urandom(32'he0f9cecb));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk({14'h0, moduleState}, 16'h0000);
        for (int k = 0; k < 3; k++)
            rdChk(roA[k], WORD_RESET);
        rdChk(ADDR_IRQ_MASK, 16'h0000);
        rdChk(ADDR_SUPPLY_ENABLE, 16'h0001);
        rdChk(16'h1234, 16'h0000);
        @(negedge sys_clk);
        chk(regRdData, 16'h0000);
        // primary supply alarms reach the fault bit only when enabled
        @(posedge sys_clk);
        supplyFlags <= 4'h1;
        for (int e = 1; e >= 0; e--)
        begin
            supEn = e[0];
            u_host_mgmt_model.wr(ADDR_SUPPLY_ENABLE, {15'h0, supEn});
            settle();
            rdChk(ADDR_FATAL_FAULT, expReg(ADDR_FATAL_FAULT));
        end
        // random monitor levels, with writes to the read-only words mixed in
        for (int i = 0; i < 60; i++)
        begin
            @(posedge sys_clk);
            initFail <= ($urandom % 4) == 0;
            checksumFail <= ($urandom % 4) == 0;
            supplyFault <= ($urandom % 2) ? 8'h00 : 8'(1 << ($urandom % 8));
            tempFlags <= 4'($urandom);
            supplyFlags <= 4'($urandom);
            ampFlags <= 4'($urandom);
            aux1Flags <= (i == 0) ? 4'hf : 4'($urandom);
            if (i % 8 == 0)
            begin
                supEn = 1'($urandom);
                u_host_mgmt_model.wr(ADDR_SUPPLY_ENABLE, {15'h0, supEn});
            end
            if (i % 5 == 0)
                u_host_mgmt_model.wr(roA[i % 4], 16'hffff);
            settle();
            for (int k = 0; k < 4; k++)
                rdChk(roA[k], expReg(roA[k]));
        end
        // quiet monitors, clear and unmask every interrupt source
        @(posedge sys_clk);
        {initFail, checksumFail, supplyFault} <= '0;
        {tempFlags, supplyFlags, ampFlags, aux1Flags} <= '0;
        settle();
        u_host_mgmt_model.wr(ADDR_IRQ_STATUS, 16'h0007);
        u_host_mgmt_model.wr(ADDR_IRQ_MASK, 16'h0007);
        rdChk(ADDR_IRQ_STATUS, 16'h0000);
        waitIrq(1'b0);
        // each word raises its own sticky bit
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            checksumFail <= (k == 0);
            ampFlags <= (k == 1) ? 4'h1 : 4'h0;
            aux1Flags <= (k == 2) ? 4'h8 : 4'h0;
            waitIrq(1'b1);
            settle();
            rdChk(ADDR_IRQ_STATUS, 16'(1 << k));
            if (k == 0)
                rdChk(ADDR_MODULE_STATE, {14'h0, MOD_FAULT});
            u_host_mgmt_model.wr(ADDR_IRQ_MASK, 16'h0000);
            waitIrq(1'b0);
            rdChk(ADDR_IRQ_STATUS, 16'(1 << k));
            u_host_mgmt_model.wr(ADDR_IRQ_MASK, 16'h0007);
            waitIrq(1'b1);
            @(posedge sys_clk);
            {checksumFail, ampFlags, aux1Flags} <= '0;
            settle();
            u_host_mgmt_model.wr(ADDR_IRQ_STATUS, 16'h0007);
            waitIrq(1'b0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
